// ### dv/shelf_alarm_checker_properties.sv
// concurrent checks on the alarm indicator lamp and contact ports
`timescale 1ns/100ps
module shelf_alarm_checker_properties
  import alarm_lamp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic critical_present,
  input wire logic major_present,
  input wire logic minor_present,
  input wire logic remote_present,
  input wire logic timing_synced,
  input wire logic feed_a_above_high,
  input wire logic feed_a_above_xhigh,
  input wire logic feed_a_below_low,
  input wire logic feed_a_below_xlow,
  input wire logic feed_b_above_xhigh,
  input wire logic feed_b_below_xlow,
  input wire logic severe_alarm_lamp,
  input wire logic second_tier_alarm_lamp,
  input wire logic third_tier_alarm_lamp,
  input wire logic far_node_alarm_lamp,
  input wire logic timing_locked_lamp,
  input wire logic silence_lamp,
  input wire logic audible_alarm_closed,
  input wire feed_colour_t feed_a_lamp,
  input wire feed_colour_t feed_b_lamp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic any_alarm;
  assign any_alarm = critical_present | major_present | minor_present | remote_present;

  ////////////////////////////////////////////////////////////////////////////////
  a_severe_lamp: assert property (critical_present |=> severe_alarm_lamp)
    else $error("severe lamp dark with critical alarm");
  a_second_lamp: assert property (major_present |=> second_tier_alarm_lamp)
    else $error("second tier lamp dark with major alarm");
  a_third_lamp: assert property (minor_present |=> third_tier_alarm_lamp)
    else $error("third tier lamp dark with minor alarm");
  a_far_lamp: assert property (remote_present |=> far_node_alarm_lamp)
    else $error("far node lamp dark with remote alarm");
  a_lock_lamp: assert property (##1 timing_locked_lamp == $past(timing_synced))
    else $error("timing lamp does not follow lock");
  a_cutoff_mutes: assert property (silence_lamp |-> !audible_alarm_closed)
    else $error("contact closed during cutoff");
  a_new_alarm_breaks: assert property (silence_lamp && ($rose(critical_present)
    || $rose(major_present) || $rose(minor_present) || $rose(remote_present))
    |-> ##[1:3] (!silence_lamp && audible_alarm_closed))
    else $error("cutoff survived a new alarm");
  a_clear_ends_cutoff: assert property (
    silence_lamp && !any_alarm |-> ##[1:2] !silence_lamp)
    else $error("cutoff held with no alarm");
  a_audible_quiet: assert property (!any_alarm [*2] |-> !audible_alarm_closed)
    else $error("contact closed with no alarm");
  a_feed_a_red: assert property (feed_a_above_xhigh || feed_a_below_xlow
    |=> feed_a_lamp == FEED_RED)
    else $error("feed a not red beyond extreme");
  a_feed_a_green: assert property (!(feed_a_above_high || feed_a_above_xhigh
    || feed_a_below_low || feed_a_below_xlow) |=> feed_a_lamp == FEED_GREEN)
    else $error("feed a not green in band");
  a_feed_b_red: assert property (feed_b_above_xhigh || feed_b_below_xlow
    |=> feed_b_lamp == FEED_RED)
    else $error("feed b not red beyond extreme");
endmodule

bind shelf_alarm_indicator_logic shelf_alarm_checker_properties i_chk (
  .mclk, .rst_n, .critical_present, .major_present, .minor_present, .remote_present,
  .timing_synced, .feed_a_above_high, .feed_a_above_xhigh, .feed_a_below_low,
  .feed_a_below_xlow, .feed_b_above_xhigh, .feed_b_below_xlow, .severe_alarm_lamp,
  .second_tier_alarm_lamp, .third_tier_alarm_lamp, .far_node_alarm_lamp,
  .timing_locked_lamp, .silence_lamp, .audible_alarm_closed, .feed_a_lamp, .feed_b_lamp
);

// ### dv/shelf_alarm_indicator_logic_bench.sv
// self-checking bench for the shelf alarm indicator logic
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module shelf_alarm_indicator_logic_bench;
  import alarm_lamp_pkg::*;
  localparam int DEB = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic silence_button = 1'b0;
  logic [3:0] alarm_req = 4'h0;
  logic sync_req = 1'b0;
  logic [2:0] lvl_a = 3'h2;
  logic [2:0] lvl_b = 3'h2;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, silence_lamp, audible_alarm_closed;
  logic severe, second, third, far, lock_lamp, timing_sync;
  logic [3:0] alarms, flags_a, flags_b;
  feed_colour_t feed_a_lamp, feed_b_lamp;
  int n_errors = 0;
  int cmp_count = 0;
  feed_colour_t exp_tab [2][5] = '{'{FEED_RED, FEED_AMBER, FEED_GREEN, FEED_AMBER, FEED_RED},
    '{FEED_RED, FEED_GREEN, FEED_GREEN, FEED_GREEN, FEED_RED}};
  wire logic [3:0] lamps_seen = {far, third, second, severe};

  always #2.5 mclk = ~mclk;

  shelf_monitor_model i_mon (.mclk(mclk), .rst_n(rst_n), .alarm_req(alarm_req),
    .sync_req(sync_req), .lvl_a(lvl_a), .lvl_b(lvl_b), .alarms(alarms),
    .timing_sync(timing_sync), .flags_a(flags_a), .flags_b(flags_b));

  shelf_alarm_indicator_logic #(.DEBOUNCE_LEN(DEB)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .critical_present(alarms[0]), .major_present(alarms[1]), .minor_present(alarms[2]),
    .remote_present(alarms[3]), .timing_synced(timing_sync),
    .silence_button(silence_button),
    .feed_a_above_high(flags_a[2]), .feed_a_above_xhigh(flags_a[3]),
    .feed_a_below_low(flags_a[1]), .feed_a_below_xlow(flags_a[0]),
    .feed_b_above_high(flags_b[2]), .feed_b_above_xhigh(flags_b[3]),
    .feed_b_below_low(flags_b[1]), .feed_b_below_xlow(flags_b[0]),
    .severe_alarm_lamp(severe), .second_tier_alarm_lamp(second),
    .third_tier_alarm_lamp(third), .far_node_alarm_lamp(far), .timing_locked_lamp(lock_lamp),
    .silence_lamp(silence_lamp), .audible_alarm_closed(audible_alarm_closed),
    .feed_a_lamp(feed_a_lamp), .feed_b_lamp(feed_b_lamp), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; pready, prdata and pslverr taken at the rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic set_in(input logic [3:0] al);
    @(posedge mclk);
    alarm_req <= al;
    repeat (4) @(negedge mclk);
  endtask

  task automatic press(input int len);
    @(posedge mclk);
    silence_button <= 1'b1;
    repeat (len) @(posedge mclk);
    silence_button <= 1'b0;
    repeat (3 * DEB + 6) @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", {29'h0, CTRL_RESET}, rd)
    apb(1'b0, INT_MASK_OFS, 32'h0);
    `CHK("mask reset", {27'h0, INT_MASK_RESET}, rd)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    for (int k = 0; k < ALARM_W; k++) begin
      set_in(4'(1 << k));
      `CHK("alarm lamps", 4'(1 << k), lamps_seen)
    end
    set_in(4'hF);
    `CHK("all alarm lamps", 4'hF, lamps_seen)
    for (int s = 1; s >= 0; s--) begin
      @(posedge mclk);
      sync_req <= 1'(s);
      repeat (4) @(negedge mclk);
      `CHK("lock lamp", 1'(s), lock_lamp)
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, CTRL_OFS, 32'(m));
      for (int l = 0; l < 5; l++) begin
        @(posedge mclk);
        lvl_a <= 3'(l);
        lvl_b <= 3'(4 - l);
        repeat (4) @(negedge mclk);
        `CHK("feed a", exp_tab[m][l], feed_a_lamp)
        `CHK("feed b", exp_tab[m][4 - l], feed_b_lamp)
      end
    end
    apb(1'b1, CTRL_OFS, 32'h0);
    // cutoff entry, break by new alarm, end by clearing
    set_in(4'h2);
    press(DEB + 4);
    `CHK("cutoff lamp", 1'b1, silence_lamp)
    `CHK("contact open", 1'b0, audible_alarm_closed)
    set_in(4'h3);
    `CHK("cutoff broken", 1'b0, silence_lamp)
    `CHK("contact closed", 1'b1, audible_alarm_closed)
    press(DEB + 4);
    set_in(4'h1);
    `CHK("cutoff held", 1'b1, silence_lamp)
    set_in(4'h0);
    `CHK("cutoff idle", 1'b0, silence_lamp)
    `CHK("contact idle", 1'b0, audible_alarm_closed)
    set_in(4'h4);
    press(2);
    `CHK("glitch ignored", 1'b0, silence_lamp)
    press(DEB + 4);
    `CHK("press taken", 1'b1, silence_lamp)
    set_in(4'h0);
    // interrupt raise, mask and clear
    apb(1'b1, INT_STATUS_OFS, 32'h1F);
    apb(1'b1, INT_MASK_OFS, 32'(1 << EV_NEW_ALARM));
    repeat (2) @(negedge mclk);
    `CHK("irq quiet", 1'b0, irq)
    set_in(4'h8);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b0, INT_STATUS_OFS, 32'h0);
    `CHK("new alarm event", 1'b1, rd[EV_NEW_ALARM])
    apb(1'b1, INT_MASK_OFS, 32'h0);
    repeat (2) @(negedge mclk);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, INT_STATUS_OFS, 32'(1 << EV_NEW_ALARM));
    apb(1'b1, INT_MASK_OFS, 32'(1 << EV_NEW_ALARM));
    repeat (2) @(negedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    // software silence pulse with the remote alarm still present
    apb(1'b1, CTRL_OFS, 32'(1 << CTRL_SW_SILENCE_BIT));
    repeat (2) @(negedge mclk);
    `CHK("soft silence lamp", 1'b1, silence_lamp)
    `CHK("soft silence contact", 1'b0, audible_alarm_closed)
    apb(1'b0, SNAPSHOT_OFS, 32'h0);
    `CHK("snapshot", 32'h8, rd)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", 32'((1 << STAT_FAR_BIT) | (1 << STAT_CUTOFF_BIT)) |
      (32'(FEED_RED) << STAT_FEED_A_LSB) | (32'(FEED_RED) << STAT_FEED_B_LSB), rd)
    set_in(4'h0);
    `CHK("soft silence idle", 1'b0, silence_lamp)
    finish_test();
  end
endmodule

// ### dv/shelf_monitor_model.sv
// behavioural model of the monitoring logic that feeds the lamp block
`timescale 1ns/100ps
module shelf_monitor_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] alarm_req,
  input wire logic sync_req,
  input wire logic [2:0] lvl_a,
  input wire logic [2:0] lvl_b,
  output logic [3:0] alarms,
  output logic timing_sync,
  output logic [3:0] flags_a,
  output logic [3:0] flags_b
);
  // level 0 extreme low .. 2 in band .. 4 extreme high
  // flags are {above_xhigh, above_high, below_low, below_xlow}
  function automatic logic [3:0] classify(input logic [2:0] l);
    return {l == 3'h4, l >= 3'h3, l <= 3'h1, l == 3'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarms <= 4'h0;
      timing_sync <= 1'b0;
      flags_a <= 4'h0;
      flags_b <= 4'h0;
    end else begin
      alarms <= alarm_req;
      timing_sync <= sync_req;
      flags_a <= classify(lvl_a);
      flags_b <= classify(lvl_b);
    end
  end
endmodule

// ### src/alarm_lamp_pkg.sv
// constants and types for the shelf alarm indicator logic
// How it works
// - severe lamp lit while any critical local alarm is present.
// - second tier lamp lit while any major local alarm is present.
// - third tier lamp lit while any minor local alarm is present.
// - far node lamp lit while any remote terminal reports an alarm.
// - timing locked lamp lit only while timing follows an external reference.
// - silence button press enters cutoff and lights the silence lamp.
// - during cutoff the audible alarm contact is held open.
// - any new alarm ends cutoff and re-enables the audible contact.
// - when the originating alarm clears, silence lamp and audible control go idle.
// - feed lamp green while supply lies between low and high thresholds.
// - feed lamp amber between high and extreme high, or low and extreme low.
// - feed lamp red above extreme high or below extreme low.
// - feed B uses the same classification as feed A.
// - two colour variant shows only green or red on feed lamps.
// - two colour variant: green between extreme low and extreme high.
// - two colour variant: red above extreme high or below extreme low.
package alarm_lamp_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;
  localparam logic [7:0] SNAPSHOT_OFS = 8'h10;

  // control register fields
  localparam int CTRL_TWO_COLOUR_BIT = 0;
  localparam int CTRL_SW_SILENCE_BIT = 1;
  localparam int CTRL_SPARE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int STAT_SEVERE_BIT = 0;
  localparam int STAT_SECOND_BIT = 1;
  localparam int STAT_THIRD_BIT = 2;
  localparam int STAT_FAR_BIT = 3;
  localparam int STAT_LOCK_BIT = 4;
  localparam int STAT_CUTOFF_BIT = 5;
  localparam int STAT_AUDIBLE_BIT = 6;
  localparam int STAT_FEED_A_LSB = 8;
  localparam int STAT_FEED_B_LSB = 10;

  // interrupt event bits
  localparam int EV_NEW_ALARM = 0;
  localparam int EV_CUTOFF_START = 1;
  localparam int EV_CUTOFF_BROKEN = 2;
  localparam int EV_CUTOFF_IDLE = 3;
  localparam int EV_FEED_CHANGE = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] INT_MASK_RESET = 5'h00;

  // alarm vector positions: critical, major, minor, remote
  localparam int ALARM_W = 4;

  // silence button debounce
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (1000000 / CLK_PERIOD_PS);
  localparam int DEB_CNT_W = 20;

  typedef enum logic [1:0] {
    FEED_OFF = 2'b00,
    FEED_GREEN = 2'b01,
    FEED_AMBER = 2'b10,
    FEED_RED = 2'b11
  } feed_colour_t;

  typedef enum logic [1:0] {
    CUT_IDLE = 2'b00,
    CUT_ACTIVE = 2'b01
  } cutoff_state_t;

endpackage

// ### src/feed_lamp_classifier.sv
// colour classification of one supply feed lamp
`timescale 1ns/100ps
module feed_lamp_classifier
  import alarm_lamp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic two_colour,
  input wire logic above_high,
  input wire logic above_xhigh,
  input wire logic below_low,
  input wire logic below_xlow,
  output feed_colour_t colour_r
);

  feed_colour_t colour_nxt;

  always_comb begin
    if (above_xhigh || below_xlow) begin
      colour_nxt = FEED_RED;
    end else if (two_colour) begin
      colour_nxt = FEED_GREEN;
    end else if (above_high || below_low) begin
      colour_nxt = FEED_AMBER;
    end else begin
      colour_nxt = FEED_GREEN;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      colour_r <= FEED_OFF;
    end else begin
      colour_r <= colour_nxt;
    end
  end

endmodule

// ### src/shelf_alarm_indicator_logic.sv
// faceplate alarm, timing and supply lamp logic with apb registers
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
module shelf_alarm_indicator_logic
  import alarm_lamp_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)(
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // monitoring inputs
  input wire logic critical_present,
  input wire logic major_present,
  input wire logic minor_present,
  input wire logic remote_present,
  input wire logic timing_synced,
  input wire logic silence_button,
  input wire logic feed_a_above_high,
  input wire logic feed_a_above_xhigh,
  input wire logic feed_a_below_low,
  input wire logic feed_a_below_xlow,
  input wire logic feed_b_above_high,
  input wire logic feed_b_above_xhigh,
  input wire logic feed_b_below_low,
  input wire logic feed_b_below_xlow,
  // lamps and contact
  output logic severe_alarm_lamp,
  output logic second_tier_alarm_lamp,
  output logic third_tier_alarm_lamp,
  output logic far_node_alarm_lamp,
  output logic timing_locked_lamp,
  output logic silence_lamp,
  output logic audible_alarm_closed,
  output feed_colour_t feed_a_lamp,
  output feed_colour_t feed_b_lamp,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [2:0] ctrl_r;
  logic [EV_W-1:0] int_status_r;
  logic [EV_W-1:0] int_mask_r;
  logic [ALARM_W-1:0] snapshot_r;
  logic [ALARM_W-1:0] alarm_prev_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic sw_silence_r;
  logic btn_meta_r;
  logic btn_sync_r;
  logic btn_stable_r;
  logic btn_stable_prev_r;
  logic [DEB_CNT_W-1:0] deb_cnt_r;
  cutoff_state_t cut_state_r;
  cutoff_state_t cut_state_nxt;
  logic severe_r;
  logic second_r;
  logic third_r;
  logic far_r;
  logic lock_r;
  logic silence_lamp_r;
  logic audible_r;
  feed_colour_t feed_a_r;
  feed_colour_t feed_b_r;
  feed_colour_t feed_a_prev_r;
  feed_colour_t feed_b_prev_r;

  logic [ALARM_W-1:0] alarm_vec;
  logic any_alarm;
  logic new_alarm;
  logic origin_cleared;
  logic press;
  logic silence_req;
  logic apb_access;
  logic apb_commit;
  logic apb_write;
  logic addr_ok;
  logic [EV_W-1:0] events;
  logic [31:0] read_mux;
  logic two_colour;

  ////////////////////////////////////////////////////////////////////////////
  // alarm vector and edges

  assign alarm_vec = {remote_present, minor_present, major_present, critical_present};
  assign any_alarm = |alarm_vec;
  assign new_alarm = |(alarm_vec & ~alarm_prev_r);
  assign origin_cleared = ~|(alarm_vec & snapshot_r);
  assign two_colour = ctrl_r[CTRL_TWO_COLOUR_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_prev_r <= '0;
    end else begin
      alarm_prev_r <= alarm_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // silence button synchroniser and debounce

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      btn_meta_r <= 1'b0;
      btn_sync_r <= 1'b0;
      btn_stable_prev_r <= 1'b0;
    end else begin
      btn_meta_r <= silence_button;
      btn_sync_r <= btn_meta_r;
      btn_stable_prev_r <= btn_stable_r;
    end
  end

  // level must hold for the full debounce length before it is accepted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deb_cnt_r <= '0;
      btn_stable_r <= 1'b0;
    end else if (btn_sync_r == btn_stable_r) begin
      deb_cnt_r <= '0;
    end else if (deb_cnt_r >= DEB_CNT_W'(DEBOUNCE_LEN - 1)) begin
      deb_cnt_r <= '0;
      btn_stable_r <= btn_sync_r;
    end else begin
      deb_cnt_r <= deb_cnt_r + 1'b1;
    end
  end

  // one pulse per debounced press
  assign press = btn_stable_r & ~btn_stable_prev_r;
  assign silence_req = press | sw_silence_r;

  ////////////////////////////////////////////////////////////////////////////
  // alarm cutoff state

  always_comb begin
    cut_state_nxt = cut_state_r;
    unique case (cut_state_r)
      CUT_IDLE: begin
        // a press with nothing sounding has nothing to silence
        if (silence_req && any_alarm && !new_alarm) begin
          cut_state_nxt = CUT_ACTIVE;
        end
      end
      CUT_ACTIVE: begin
        if (new_alarm) begin
          cut_state_nxt = CUT_IDLE;
        end else if (origin_cleared) begin
          cut_state_nxt = CUT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cut_state_r <= CUT_IDLE;
    end else begin
      cut_state_r <= cut_state_nxt;
    end
  end

  // alarms present when cutoff began
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snapshot_r <= '0;
    end else if (cut_state_r == CUT_IDLE && cut_state_nxt == CUT_ACTIVE) begin
      snapshot_r <= alarm_vec;
    end else if (cut_state_nxt == CUT_IDLE) begin
      snapshot_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm lamps, silence lamp and audible contact

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      severe_r <= 1'b0;
      second_r <= 1'b0;
      third_r <= 1'b0;
      far_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      severe_r <= critical_present;
      second_r <= major_present;
      third_r <= minor_present;
      far_r <= remote_present;
      lock_r <= timing_synced;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      silence_lamp_r <= 1'b0;
      audible_r <= 1'b0;
    end else begin
      silence_lamp_r <= (cut_state_nxt == CUT_ACTIVE);
      audible_r <= any_alarm & (cut_state_nxt == CUT_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply feed lamps

  feed_lamp_classifier u_feed_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .two_colour(two_colour),
    .above_high(feed_a_above_high),
    .above_xhigh(feed_a_above_xhigh),
    .below_low(feed_a_below_low),
    .below_xlow(feed_a_below_xlow),
    .colour_r(feed_a_r)
  );

  feed_lamp_classifier u_feed_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .two_colour(two_colour),
    .above_high(feed_b_above_high),
    .above_xhigh(feed_b_above_xhigh),
    .below_low(feed_b_below_low),
    .below_xlow(feed_b_below_xlow),
    .colour_r(feed_b_r)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      feed_a_prev_r <= FEED_OFF;
      feed_b_prev_r <= FEED_OFF;
    end else begin
      feed_a_prev_r <= feed_a_r;
      feed_b_prev_r <= feed_b_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer in second access cycle

  assign apb_access = psel & penable & ~pready_r;
  assign apb_commit = psel & penable & pready_r;
  assign apb_write = apb_commit & pwrite;
  assign addr_ok = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) ||
                   (paddr == INT_STATUS_OFS) || (paddr == INT_MASK_OFS) ||
                   (paddr == SNAPSHOT_OFS);

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFS: read_mux[2:0] = ctrl_r;
      STATUS_OFS: begin
        read_mux[STAT_SEVERE_BIT] = severe_r;
        read_mux[STAT_SECOND_BIT] = second_r;
        read_mux[STAT_THIRD_BIT] = third_r;
        read_mux[STAT_FAR_BIT] = far_r;
        read_mux[STAT_LOCK_BIT] = lock_r;
        read_mux[STAT_CUTOFF_BIT] = (cut_state_r == CUT_ACTIVE);
        read_mux[STAT_AUDIBLE_BIT] = audible_r;
        read_mux[STAT_FEED_A_LSB +: 2] = feed_a_r;
        read_mux[STAT_FEED_B_LSB +: 2] = feed_b_r;
      end
      INT_STATUS_OFS: read_mux[EV_W-1:0] = int_status_r;
      INT_MASK_OFS: read_mux[EV_W-1:0] = int_mask_r;
      SNAPSHOT_OFS: read_mux[ALARM_W-1:0] = snapshot_r;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (apb_access) begin
      pready_r <= 1'b1;
      pslverr_r <= ~addr_ok;
      prdata_r <= pwrite ? 32'h0000_0000 : read_mux;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
  end

  // control: variant select, spare storage bit; silence bit is a write pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
      sw_silence_r <= 1'b0;
    end else if (apb_write && paddr == CTRL_OFS) begin
      ctrl_r[CTRL_TWO_COLOUR_BIT] <= pwdata[CTRL_TWO_COLOUR_BIT];
      ctrl_r[CTRL_SPARE_BIT] <= pwdata[CTRL_SPARE_BIT];
      ctrl_r[CTRL_SW_SILENCE_BIT] <= 1'b0;
      sw_silence_r <= pwdata[CTRL_SW_SILENCE_BIT];
    end else begin
      sw_silence_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_r <= INT_MASK_RESET;
    end else if (apb_write && paddr == INT_MASK_OFS) begin
      int_mask_r <= pwdata[EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins

  always_comb begin
    events = '0;
    events[EV_NEW_ALARM] = new_alarm;
    events[EV_CUTOFF_START] = (cut_state_r == CUT_IDLE) && (cut_state_nxt == CUT_ACTIVE);
    events[EV_CUTOFF_BROKEN] = (cut_state_r == CUT_ACTIVE) && new_alarm;
    events[EV_CUTOFF_IDLE] = (cut_state_r == CUT_ACTIVE) && !new_alarm && origin_cleared;
    events[EV_FEED_CHANGE] = (feed_a_r != feed_a_prev_r) || (feed_b_r != feed_b_prev_r);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_status_r <= '0;
    end else if (apb_write && paddr == INT_STATUS_OFS) begin
      int_status_r <= (int_status_r & ~pwdata[EV_W-1:0]) | events;
    end else begin
      int_status_r <= int_status_r | events;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_status_r & int_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign severe_alarm_lamp = severe_r;
  assign second_tier_alarm_lamp = second_r;
  assign third_tier_alarm_lamp = third_r;
  assign far_node_alarm_lamp = far_r;
  assign timing_locked_lamp = lock_r;
  assign silence_lamp = silence_lamp_r;
  assign audible_alarm_closed = audible_r;
  assign feed_a_lamp = feed_a_r;
  assign feed_b_lamp = feed_b_r;
  assign irq = irq_r;

endmodule
